/* File: rtl/hbd_pkg.sv */
/*
 * hbd_pkg: constants, types and carriers for the three half-bridge decoder
 * and current limiter.
 * assumes a single 50 MHz system clock; analog comparisons arrive as digital flags.
 */
`default_nettype none

package hbd_pkg;
    // ------------------------------------------------------------
    // sizes and timing
    // ------------------------------------------------------------
    localparam int HBD_PHASES = 3;                  // number of half bridges
    localparam int HBD_CLK_HZ = 50000000;           // system clock rate
    localparam int HBD_CHOP_SLOW_HZ = 20000;        // full-duty pulse rate, low setting
    localparam int HBD_CHOP_FAST_HZ = 40000;        // full-duty pulse rate, high setting
    // longest period rounds down; both stay well under 4096 cycles
    localparam int HBD_CHOP_SLOW_CYC = HBD_CLK_HZ / HBD_CHOP_SLOW_HZ;
    localparam int HBD_CHOP_FAST_CYC = HBD_CLK_HZ / HBD_CHOP_FAST_HZ;
    localparam int HBD_CNT_W = 12;                  // width of the chopping counter
    localparam logic [HBD_CNT_W-1:0] HBD_CNT_ZERO = 12'h000;
    localparam logic [HBD_CNT_W-1:0] HBD_CNT_ONE = 12'h001;
    localparam logic [HBD_CNT_W-1:0] HBD_SLOW_LAST = 12'(HBD_CHOP_SLOW_CYC - 1);
    localparam logic [HBD_CNT_W-1:0] HBD_FAST_LAST = 12'(HBD_CHOP_FAST_CYC - 1);
    localparam logic [2:0] HBD_SYNC_ZERO = 3'h0;    // reset value of a synchroniser

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef logic [HBD_PHASES-1:0] hbd_phase_t;     // one bit per phase

    typedef struct packed {
        hbd_phase_t pwm;     // phase_pwm_in per phase
        hbd_phase_t enable;  // phase_enable_in per phase
        hbd_phase_t over;    // current above current_limit_ref, per phase
    } hbd_in_s;

    typedef struct packed {
        hbd_phase_t level;   // phase_output level while driven
        hbd_phase_t oe;      // phase_output drive enable, 0 is high impedance
    } hbd_out_s;
endpackage

`default_nettype wire

/* File: rtl/hbd_sync.sv */
/*
 * hbd_sync: three-stage synchroniser with agreement filter for one pin.
 * assumes an asynchronous pin; output changes once stages two and three agree.
 */
`default_nettype none

module hbd_sync (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // pin and clean level
    input wire logic pin,
    output logic level
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] stage; // stage 0 is read only by stage 1
        logic level;       // filtered level
    } hbd_sync_s;

    hbd_sync_s st_reg;
    hbd_sync_s st_next;

    // next state: shift, update level when the two late stages agree
    always_comb begin
        st_next = st_reg;
        st_next.stage = {st_reg.stage[1:0], pin};
        if (st_reg.stage[1] == st_reg.stage[2]) begin
            st_next.level = st_reg.stage[2];
        end
    end

    // registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '{stage: hbd_pkg::HBD_SYNC_ZERO, level: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign level = st_reg.level;
endmodule

`default_nettype wire

/* File: rtl/hbd_top.sv */
/*
 * hbd_top: per-phase enable-plus-pwm decoder for three half bridges with
 * cycle-by-cycle current limiting and an internal full-duty chopping pulse.
 * assumes the comparator outputs (current above limit, reference at mid rail)
 * arrive as asynchronous digital levels; the analog front end lives elsewhere.
 */
// Behaviour
// - enable low floats; else output follows pwm
// - both pwm low, both enabled: low-side brake
// - limit applies only in current-limit mode
// - reference at mid rail disables the limit
// - full duty gets internal chopping restart pulse
// - chopping rate selects 20kHz or 40kHz
`default_nettype none

module hbd_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // pins from the microcontroller, asynchronous
    input wire logic [2:0] phase_pwm_in,
    input wire logic [2:0] phase_enable_in,
    // configuration straps, asynchronous
    input wire logic current_limit_mode,
    input wire logic chop_rate_fast,
    // comparator flags, asynchronous
    input wire logic [2:0] phase_over_limit,
    input wire logic limit_ref_mid_rail,
    // phase outputs: level and drive enable
    output logic [2:0] phase_output,
    output logic [2:0] phase_output_oe,
    // cut status per phase
    output logic [2:0] phase_limit_active
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 3 * hbd_pkg::HBD_PHASES + 3;
    logic [NSYNC-1:0] raw_pins;
    logic [NSYNC-1:0] clean;
    hbd_pkg::hbd_in_s pin_s;
    logic mode_cl;
    logic fast_sel;
    logic ref_mid;

    // bit order must match the carrier: pwm in its top field, overcurrent in its bottom one
    // straps and the mid-rail flag ride above the carrier bits
    assign raw_pins = {limit_ref_mid_rail, chop_rate_fast, current_limit_mode,
                       phase_pwm_in, phase_enable_in, phase_over_limit};

    // one synchroniser per pin
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            hbd_sync u_sync (
                .sys_clk(sys_clk),
                .rstn(rstn),
                .pin(raw_pins[gi]),
                .level(clean[gi])
            );
        end
    endgenerate

    assign pin_s = hbd_pkg::hbd_in_s'(clean[3*hbd_pkg::HBD_PHASES-1:0]);
    assign mode_cl = clean[3*hbd_pkg::HBD_PHASES];
    assign fast_sel = clean[3*hbd_pkg::HBD_PHASES+1];
    assign ref_mid = clean[3*hbd_pkg::HBD_PHASES+2];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [hbd_pkg::HBD_CNT_W-1:0] chop_cnt; // full-duty period counter
        logic chop_pulse;                        // one-cycle restart pulse
        hbd_pkg::hbd_phase_t pwm_d;              // previous pwm, for rising edges
        hbd_pkg::hbd_phase_t cut;                // drive cut by overcurrent
        hbd_pkg::hbd_out_s drv;                  // registered outputs
        logic [hbd_pkg::HBD_CNT_W-1:0] fast_gap; // cycles since a pulse at the fast rate, checks only
        logic [hbd_pkg::HBD_CNT_W-1:0] slow_gap; // cycles since a pulse at the slow rate, checks only
    } hbd_state_s;

    hbd_state_s st_reg;
    hbd_state_s st_next;
    logic limit_on;
    hbd_pkg::hbd_phase_t restart;
    logic [hbd_pkg::HBD_CNT_W-1:0] chop_last;

    // limiting is live only in current-limit mode and with a real reference
    assign limit_on = mode_cl && !ref_mid;
    // period end follows the selected rate
    assign chop_last = fast_sel ? hbd_pkg::HBD_FAST_LAST : hbd_pkg::HBD_SLOW_LAST;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.pwm_d = pin_s.pwm;
        // counter free-runs so a pwm held high still gets restarts
        st_next.chop_pulse = 1'b0;
        if (st_reg.chop_cnt >= chop_last) begin
            st_next.chop_cnt = hbd_pkg::HBD_CNT_ZERO;
            st_next.chop_pulse = 1'b1;
        end else begin
            st_next.chop_cnt = st_reg.chop_cnt + hbd_pkg::HBD_CNT_ONE;
        end
        // watchdog counts for the rate assertions; a pulse or the other rate clears them
        // clearing on the pulse itself keeps a full period at the last count exactly
        if (st_next.chop_pulse || !fast_sel) begin
            st_next.fast_gap = hbd_pkg::HBD_CNT_ZERO;
        end else begin
            st_next.fast_gap = st_reg.fast_gap + hbd_pkg::HBD_CNT_ONE;
        end
        // the slow count mirrors the fast one with the rate test inverted
        if (st_next.chop_pulse || fast_sel) begin
            st_next.slow_gap = hbd_pkg::HBD_CNT_ZERO;
        end else begin
            st_next.slow_gap = st_reg.slow_gap + hbd_pkg::HBD_CNT_ONE;
        end
        // a new period starts on a pwm rising edge or the chopping pulse
        restart = (pin_s.pwm & ~st_reg.pwm_d) | {hbd_pkg::HBD_PHASES{st_reg.chop_pulse}};
        for (int p = 0; p < hbd_pkg::HBD_PHASES; p++) begin
            // overcurrent wins over a restart in the same cycle
            if (!limit_on) begin
                st_next.cut[p] = 1'b0;
            end else if (pin_s.over[p] && pin_s.enable[p] && pin_s.pwm[p]) begin
                st_next.cut[p] = 1'b1;
            end else if (restart[p]) begin
                st_next.cut[p] = 1'b0;
            end
            // decode: float when disabled, else follow pwm; a cut drives low
            st_next.drv.oe[p] = pin_s.enable[p];
            // pwm low with enable gives low on both legs of a bridge: brake
            st_next.drv.level[p] = pin_s.enable[p] && pin_s.pwm[p] && !st_next.cut[p];
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign phase_output = st_reg.drv.level;
    assign phase_output_oe = st_reg.drv.oe;
    assign phase_limit_active = st_reg.cut;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // checks only; the gap counters in the state exist for them and feed no output
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // decode: what the core sees appears on the pins one edge later
    a_float_disabled: assert property (!pin_s.enable[0] |=> !phase_output_oe[0])
        else $error("phase 0 driven while disabled");
    a_coast_all: assert property (pin_s.enable == 3'h0 |=> phase_output_oe == 3'h0)
        else $error("a phase driven with every enable low");
    a_follow_pwm: assert property (
        pin_s.enable[1] && pin_s.pwm[1] && !st_next.cut[1] |=> phase_output_oe[1] && phase_output[1])
        else $error("phase 1 not high for pwm high");
    a_drive_low: assert property (
        pin_s.enable[2] && !pin_s.pwm[2] |=> phase_output_oe[2] && !phase_output[2])
        else $error("phase 2 not low for pwm low");
    // two enabled phases with pwm low form the low-side brake of a bridge
    a_bridge_brake: assert property (
        pin_s.enable[1:0] == 2'h3 && pin_s.pwm[1:0] == 2'h0
        |=> phase_output_oe[1:0] == 2'h3 && phase_output[1:0] == 2'h0)
        else $error("bridge not braking low");

    // limit gating: outside the mode or at a mid-rail reference nothing may stay cut
    a_no_limit_off: assert property (!mode_cl |=> phase_limit_active == 3'h0)
        else $error("limit active outside limit mode");
    a_mid_rail_off: assert property (ref_mid |=> phase_limit_active == 3'h0)
        else $error("limit active with mid-rail reference");

    // chopping rate: at the fast rate no pulse 8 cycles after a pulse, and a pulse never comes late
    // the gap counters stand in for a long delay range, which the tools unroll badly
    a_chop_period: assert property (
        $rose(st_reg.chop_pulse) && fast_sel ##1 fast_sel [*8] |-> !st_reg.chop_pulse)
        else $error("chopping pulse repeats too soon");
    // both counts clear on the pulse itself, so one full period tops out at the last count
    a_chop_fast: assert property (st_reg.fast_gap <= hbd_pkg::HBD_FAST_LAST)
        else $error("no chopping pulse within fast period");
    a_chop_slow: assert property (st_reg.slow_gap <= hbd_pkg::HBD_SLOW_LAST)
        else $error("no chopping pulse within slow period");

    // cut: set by overcurrent, held until a restart, never leaves a phase high
    a_cut_on_over: assert property (
        limit_on && pin_s.over[2] && pin_s.enable[2] && pin_s.pwm[2] |=> phase_limit_active[2] && !phase_output[2])
        else $error("overcurrent did not cut drive");
    a_cut_holds: assert property (
        phase_limit_active[0] && limit_on && !restart[0] |=> phase_limit_active[0])
        else $error("cut released without restart");
    a_cut_clears: assert property (
        phase_limit_active[0] && limit_on && restart[0]
        && !(pin_s.over[0] && pin_s.enable[0] && pin_s.pwm[0]) |=> !phase_limit_active[0])
        else $error("cut kept after restart");
    // overcurrent only counts while the phase is enabled and driving high
    a_over_refused: assert property (
        !phase_limit_active[2] && !pin_s.pwm[2] |=> !phase_limit_active[2])
        else $error("cut set while pwm low");
    // level and cut come from the same next state, so they can never overlap
    a_cut_drives_low: assert property ((phase_limit_active & phase_output) == 3'h0)
        else $error("cut phase still driven high");

    // main scenarios: full-duty release, brake, cut, coast and fast-rate chopping
    // a cover that never hits marks a scenario the bench misses
    c_full_duty_chop: cover property (limit_on && pin_s.pwm[0] && $fell(phase_limit_active[0]));
    c_brake: cover property (phase_output_oe[1:0] == 2'h3 && phase_output[1:0] == 2'h0);
    c_cut: cover property ($rose(phase_limit_active[2]));
    c_coast: cover property (phase_output_oe == 3'h0);
    c_fast_chop: cover property (fast_sel && $fell(phase_limit_active[0]));
endmodule

`default_nettype wire

/* File: verification/hbd_mcu_model.sv */
/*
 * hbd_mcu_model: stand-in for the controller driving pwm and enable pins.
 * assumes the bench hands it the wanted pin levels; pins move on falling edges.
 */
`default_nettype none

module hbd_mcu_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // wanted levels from the bench
    input wire logic [2:0] cmd_pwm,
    input wire logic [2:0] cmd_enable,
    // pins toward the driver
    output logic [2:0] phase_pwm_in,
    output logic [2:0] phase_enable_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    // pins idle low so every phase floats until commanded
    always @(negedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            phase_pwm_in <= 3'h0;
            phase_enable_in <= 3'h0;
        end else begin
            phase_pwm_in <= cmd_pwm;
            phase_enable_in <= cmd_enable;
        end
    end
endmodule

`default_nettype wire

/* File: verification/tb_half_bridge_decode_current_limit.sv */
/*
 * tb_half_bridge_decode_current_limit: self-checking bench for hbd_top.
 * assumes hbd_pkg and the controller model are compiled first.
 */
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end

module tb_half_bridge_decode_current_limit;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] cmd_pwm = 3'h0, cmd_enable = 3'h0, pwm, en, over = 3'h0;
    logic mode = 1'b0, fast = 1'b0, mid = 1'b0;
    logic [2:0] out, oe, cut;
    int miscompares = 0, n_tests = 0, cyc = 0, t1, t2;

    always #10 sys_clk = ~sys_clk;

    hbd_mcu_model mcu (.sys_clk(sys_clk), .rstn(rstn), .cmd_pwm(cmd_pwm), .cmd_enable(cmd_enable),
        .phase_pwm_in(pwm), .phase_enable_in(en));
    hbd_top dut (.sys_clk(sys_clk), .rstn(rstn), .phase_pwm_in(pwm), .phase_enable_in(en),
        .current_limit_mode(mode), .chop_rate_fast(fast), .phase_over_limit(over),
        .limit_ref_mid_rail(mid), .phase_output(out), .phase_output_oe(oe), .phase_limit_active(cut));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // hang guard sized well beyond the longest chop measurements
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    // let pins cross the synchronisers and output register
    task automatic settle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // bounded wait until phase 0 drive is restored
    task automatic wait_clear(output int t);
        int k;
        for (k = 0; k < 3000 && cut[0] !== 1'b0; k++) @(negedge sys_clk);
        t = cyc;
        `CHK("cut_cleared", 1'b0, cut[0])
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h94824e07));
        settle(10);
        rstn = 1'b1;
        // random decode with brake and coast corners first
        for (int i = 0; i < 40; i++) begin
            cmd_enable = (i == 0) ? 3'h7 : (i == 1) ? 3'h0 : 3'($urandom);
            cmd_pwm = (i < 2) ? 3'h0 : 3'($urandom);
            mode = 1'($urandom);
            settle(9);
            `CHK("oe", cmd_enable, oe)
            `CHK("level", cmd_pwm & cmd_enable, out)
        end
        // overcurrent ignored outside limit mode, then at mid rail
        cmd_enable = 3'h7;
        cmd_pwm = 3'h7;
        over = 3'h1;
        for (int m = 0; m < 2; m++) begin
            mode = 1'(m);
            mid = 1'(m);
            settle(9);
            `CHK("cut_off", 3'h0, cut)
            `CHK("level_on", 3'h7, out)
        end
        // limit mode: cut low-drives the phase, pwm restart restores it
        mid = 1'b0;
        settle(9);
        `CHK("cut", 3'h1, cut)
        `CHK("cut_level", 3'h6, out)
        `CHK("cut_oe", 3'h7, oe)
        over = 3'h0;
        cmd_pwm = 3'h6;
        settle(6);
        cmd_pwm = 3'h7;
        settle(9);
        `CHK("restart", 3'h0, cut)
        // full duty: clears land one chop period apart at each rate
        for (int r = 0; r < 2; r++) begin
            fast = 1'(r);
            over = 3'h1;
            settle(9);
            over = 3'h0;
            wait_clear(t1);
            over = 3'h1;
            settle(9);
            over = 3'h0;
            wait_clear(t2);
            `CHK("chop_period", hbd_pkg::HBD_CLK_HZ / (r ? 40000 : 20000), t2 - t1)
        end
        tally_and_finish();
    end
endmodule

`undef CHK
`default_nettype wire
